//--- dttf_consts.vh
`ifndef DTTF_CONSTS_VH
`define DTTF_CONSTS_VH

// clock and time base
`define DTTF_CLK_PERIOD_PS   4000
`define DTTF_US_PS           1000000
`define DTTF_US_CYCLES       (`DTTF_US_PS / `DTTF_CLK_PERIOD_PS)

// ticket formats
`define DTTF_FMT_STATUS      2'h0
`define DTTF_FMT_MULTI_SHORT 2'h1
`define DTTF_FMT_MULTI_FULL  2'h2
`define DTTF_LEN_STATUS      6'h1f
`define DTTF_LEN_MULTI_SHORT 6'h1d
`define DTTF_LEN_MULTI_FULL  6'h31
`define DTTF_WORD_TIME       6'h00
`define DTTF_WORD_ZERO       6'h08

// error codes
`define DTTF_ERR_NONE        8'h00
`define DTTF_ERR_OVER_TEMP   8'h10
`define DTTF_ERR_UNDER_VOLT  8'h11
`define DTTF_ERR_OVER_VOLT   8'h12
`define DTTF_ERR_OVER_SPEED  8'h13
`define DTTF_ERR_POS_SOFT    8'h14
`define DTTF_ERR_NEG_SOFT    8'h15
`define DTTF_ERR_NEG_SWITCH  8'h16
`define DTTF_ERR_POS_SWITCH  8'h17
`define DTTF_ERR_HOME_TMO    8'h19
`define DTTF_ERR_SENSOR      8'h1a
`define DTTF_ERR_STAGE       8'h1b
`define DTTF_ERR_WDOG        8'h1c
`define DTTF_ERR_INDEX_DIST  8'h32

// fault thresholds, units as delivered by the measurement logic
`define DTTF_TEMP_MAX_DECI   32'sd850
`define DTTF_VOLT_MIN_MV     32'sd10000
`define DTTF_VOLT_MAX_MV     32'sd30000
`define DTTF_SPEED_MAX_RPM   32'sd2000
`define DTTF_INDEX_MIN_DECI  16'h0032

// host commands and objects
`define DTTF_SYS_CLR_ERR     8'h05
`define DTTF_OBJ_MAIN_ERR    8'h03
`define DTTF_OBJ_SUB_ERR     8'h04

// long timeouts in microseconds
`define DTTF_HOME_TMO_US     300000000
`define DTTF_WDOG_TMO_US     100000

`endif

//--- dttf_err_mem.v
`timescale 1ns/1ps
// small ring store of recent error codes, registered read data
module dttf_err_mem #(
  parameter AW = 3,
  parameter DW = 8
) (
  input  wire          clk_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule

//--- dttf_framer.v
// How it works
// - status ticket is 31 words: time, drive readings, slave positions
// - multi-axis tickets only go out while this drive is chain master
// - short multi-axis ticket: time, 9 positions, 9 modes, 9 states, temp
// - full multi-axis ticket: 49 words, five groups of nine, three temps
// - recent error codes kept in a store the host can read back
// - board temperature above 85 C disables motor, records code 16
// - supply below 10 V disables motor, saves states, records code 17
// - supply above 30 V disables motor, records code 18
// - speed above 2000 RPM brakes motor, records code 19
// - software position limits stop motor, record code 20 or 21
// - referenced axis limit switches record 22 negative, 23 positive
// - limit switch search without a hit in 300 s records code 25
// - failed position sensor calibration check records code 26
// - power stage undervoltage or overtemperature records code 27
// - enabled watchdog not reset by host records 28, motor off
// - limit switch under 5 degrees from index pulse records code 50
// - system command mode 5 clears the last-error record
// - last error readable as object 3.4; writing 0 there clears it
`timescale 1ns/1ps
`include "dttf_consts.vh"
module dttf_framer #(
  parameter HOME_TMO_US = `DTTF_HOME_TMO_US,
  parameter WDOG_TMO_US = `DTTF_WDOG_TMO_US,
  parameter HIST_AW     = 3
) (
  input  wire               CORE_CLK_IN,
  input  wire               SYS_RST_IN,
  input  wire               TICKET_REQ_IN,
  input  wire [1:0]         TICKET_FMT_IN,
  input  wire               CAN_MASTER_IN,
  input  wire [31:0]        WORD_DATA_IN,
  input  wire               TX_READY_IN,
  input  wire signed [31:0] BOARD_TEMP_IN,
  input  wire signed [31:0] SUPPLY_MV_IN,
  input  wire signed [31:0] SPEED_RPM_IN,
  input  wire               POS_SOFT_LIM_IN,
  input  wire               NEG_SOFT_LIM_IN,
  input  wire               POS_SWITCH_IN,
  input  wire               NEG_SWITCH_IN,
  input  wire               REF_SWITCH_CFG_IN,
  input  wire               AXIS_REFERENCED_IN,
  input  wire               HOME_SEARCH_IN,
  input  wire               CALIB_FAIL_IN,
  input  wire               STAGE_FAULT_IN,
  input  wire               WDOG_EN_IN,
  input  wire               WDOG_KICK_IN,
  input  wire [15:0]        INDEX_DIST_IN,
  input  wire               INDEX_DIST_VALID_IN,
  input  wire               SYS_CMD_VALID_IN,
  input  wire [7:0]         SYS_CMD_MODE_IN,
  input  wire               OBJ_READ_IN,
  input  wire               OBJ_WRITE_IN,
  input  wire [7:0]         OBJ_MAIN_IN,
  input  wire [7:0]         OBJ_SUB_IN,
  input  wire [31:0]        OBJ_WDATA_IN,
  input  wire [HIST_AW-1:0] HIST_IDX_IN,
  output reg                BUSY_OUT,
  output reg                TICKET_REJECT_OUT,
  output reg  [1:0]         WORD_FMT_OUT,
  output reg  [5:0]         WORD_IDX_OUT,
  output reg  [7:0]         TX_DATA_OUT,
  output reg                TX_VALID_OUT,
  output reg                TX_LAST_OUT,
  output reg                MOTOR_DISABLE_OUT,
  output reg                MOTOR_BRAKE_OUT,
  output reg                MOTOR_STOP_OUT,
  output reg                SAVE_STATE_OUT,
  output reg                ERROR_EVENT_OUT,
  output reg  [7:0]         LAST_ERROR_OUT,
  output reg  [31:0]        OBJ_RDATA_OUT,
  output reg                OBJ_RVALID_OUT,
  output wire [7:0]         HIST_DATA_OUT,
  output reg  [HIST_AW-1:0] HIST_NEXT_OUT
);
  localparam NC = 13;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_SEL  = 4'h2;
  localparam [3:0] S_LOAD = 4'h4;
  localparam [3:0] S_SEND = 4'h8;
  localparam integer US_CYC = `DTTF_US_CYCLES;

  // condition slot to error code
  function [7:0] code_of;
    input [3:0] slot;
    begin
      case (slot)
        4'h0:    code_of = `DTTF_ERR_OVER_TEMP;
        4'h1:    code_of = `DTTF_ERR_UNDER_VOLT;
        4'h2:    code_of = `DTTF_ERR_OVER_VOLT;
        4'h3:    code_of = `DTTF_ERR_OVER_SPEED;
        4'h4:    code_of = `DTTF_ERR_POS_SOFT;
        4'h5:    code_of = `DTTF_ERR_NEG_SOFT;
        4'h6:    code_of = `DTTF_ERR_NEG_SWITCH;
        4'h7:    code_of = `DTTF_ERR_POS_SWITCH;
        4'h8:    code_of = `DTTF_ERR_HOME_TMO;
        4'h9:    code_of = `DTTF_ERR_SENSOR;
        4'ha:    code_of = `DTTF_ERR_STAGE;
        4'hb:    code_of = `DTTF_ERR_WDOG;
        4'hc:    code_of = `DTTF_ERR_INDEX_DIST;
        default: code_of = `DTTF_ERR_NONE;
      endcase
    end
  endfunction

  function [5:0] len_of;
    input [1:0] fmt;
    begin
      case (fmt)
        `DTTF_FMT_MULTI_SHORT: len_of = `DTTF_LEN_MULTI_SHORT;
        `DTTF_FMT_MULTI_FULL:  len_of = `DTTF_LEN_MULTI_FULL;
        default:               len_of = `DTTF_LEN_STATUS;
      endcase
    end
  endfunction

  // pin-level inputs pass two flops before use
  reg [4:0] pin_m_r;
  reg [4:0] pin_s_r;
  always @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      pin_m_r <= 5'h00;
      pin_s_r <= 5'h00;
    end else begin
      pin_m_r <= {STAGE_FAULT_IN, POS_SWITCH_IN, NEG_SWITCH_IN,
                  POS_SOFT_LIM_IN, NEG_SOFT_LIM_IN};
      pin_s_r <= pin_m_r;
    end
  end

  // microsecond time base, shared by ticket time word and timeouts
  reg  [7:0]  us_div_r;
  reg  [31:0] time_us_r;
  wire        us_tick = (us_div_r == US_CYC[7:0] - 8'h01);
  always @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      us_div_r  <= 8'h00;
      time_us_r <= 32'h0000_0000;
    end else if (us_tick) begin
      us_div_r  <= 8'h00;
      time_us_r <= time_us_r + 32'h0000_0001;
    end else begin
      us_div_r  <= us_div_r + 8'h01;
    end
  end

  // ticket sequencer
  reg [3:0]  st_r;
  reg [5:0]  len_r;
  reg [31:0] stamp_r;
  reg [31:0] shift_r;
  reg [1:0]  byte_r;
  wire       tx_take = TX_VALID_OUT && TX_READY_IN;
  wire       last_wd = (WORD_IDX_OUT == len_r - 6'h01);
  wire       fmt_multi = (TICKET_FMT_IN == `DTTF_FMT_MULTI_SHORT) ||
                         (TICKET_FMT_IN == `DTTF_FMT_MULTI_FULL);
  always @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      st_r              <= S_IDLE;
      len_r             <= `DTTF_LEN_STATUS;
      stamp_r           <= 32'h0000_0000;
      shift_r           <= 32'h0000_0000;
      byte_r            <= 2'h0;
      BUSY_OUT          <= 1'b0;
      TICKET_REJECT_OUT <= 1'b0;
      WORD_FMT_OUT      <= `DTTF_FMT_STATUS;
      WORD_IDX_OUT      <= 6'h00;
      TX_DATA_OUT       <= 8'h00;
      TX_VALID_OUT      <= 1'b0;
      TX_LAST_OUT       <= 1'b0;
    end else begin
      TICKET_REJECT_OUT <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (TICKET_REQ_IN) begin
            if ((fmt_multi && !CAN_MASTER_IN) || TICKET_FMT_IN == 2'h3) begin
              TICKET_REJECT_OUT <= 1'b1;
            end else begin
              len_r        <= len_of(TICKET_FMT_IN);
              WORD_FMT_OUT <= TICKET_FMT_IN;
              WORD_IDX_OUT <= 6'h00;
              stamp_r      <= time_us_r;
              BUSY_OUT     <= 1'b1;
              st_r         <= S_SEL;
            end
          end
        end
        S_SEL: begin
          // source answers one cycle after the index settles
          st_r <= S_LOAD;
        end
        S_LOAD: begin
          if (WORD_IDX_OUT == `DTTF_WORD_TIME) begin
            shift_r <= stamp_r;
          end else if (WORD_FMT_OUT == `DTTF_FMT_STATUS &&
                       WORD_IDX_OUT == `DTTF_WORD_ZERO) begin
            shift_r <= 32'h0000_0000;
          end else begin
            shift_r <= WORD_DATA_IN;
          end
          byte_r       <= 2'h0;
          TX_VALID_OUT <= 1'b1;
          TX_LAST_OUT  <= 1'b0;
          TX_DATA_OUT  <= (WORD_IDX_OUT == `DTTF_WORD_TIME) ? stamp_r[7:0] :
                          (WORD_FMT_OUT == `DTTF_FMT_STATUS &&
                           WORD_IDX_OUT == `DTTF_WORD_ZERO) ? 8'h00 :
                          WORD_DATA_IN[7:0];
          st_r         <= S_SEND;
        end
        S_SEND: begin
          if (tx_take) begin
            if (byte_r == 2'h3) begin
              TX_VALID_OUT <= 1'b0;
              TX_LAST_OUT  <= 1'b0;
              if (last_wd) begin
                BUSY_OUT <= 1'b0;
                st_r     <= S_IDLE;
              end else begin
                WORD_IDX_OUT <= WORD_IDX_OUT + 6'h01;
                st_r         <= S_SEL;
              end
            end else begin
              byte_r      <= byte_r + 2'h1;
              shift_r     <= {8'h00, shift_r[31:8]};
              TX_DATA_OUT <= shift_r[15:8];
              TX_LAST_OUT <= last_wd && (byte_r == 2'h2);
            end
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // watchdog and search timers in microseconds
  reg [31:0] wdog_cnt_r;
  reg [31:0] home_cnt_r;
  reg        wdog_exp_r;
  reg        home_exp_r;
  always @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      wdog_cnt_r <= 32'h0000_0000;
      home_cnt_r <= 32'h0000_0000;
      wdog_exp_r <= 1'b0;
      home_exp_r <= 1'b0;
    end else begin
      if (!WDOG_EN_IN || WDOG_KICK_IN) begin
        wdog_cnt_r <= 32'h0000_0000;
        wdog_exp_r <= 1'b0;
      end else if (us_tick && !wdog_exp_r) begin
        wdog_cnt_r <= wdog_cnt_r + 32'h0000_0001;
        wdog_exp_r <= (wdog_cnt_r == WDOG_TMO_US - 1);
      end
      if (!HOME_SEARCH_IN || pin_s_r[2] || pin_s_r[3]) begin
        home_cnt_r <= 32'h0000_0000;
        home_exp_r <= 1'b0;
      end else if (us_tick && !home_exp_r) begin
        home_cnt_r <= home_cnt_r + 32'h0000_0001;
        home_exp_r <= (home_cnt_r == HOME_TMO_US - 1);
      end
    end
  end

  // fault conditions, one slot per error code
  wire          ref_sw = REF_SWITCH_CFG_IN && AXIS_REFERENCED_IN;
  wire [NC-1:0] cond;
  assign cond[0]  = BOARD_TEMP_IN > `DTTF_TEMP_MAX_DECI;
  assign cond[1]  = SUPPLY_MV_IN < `DTTF_VOLT_MIN_MV;
  assign cond[2]  = SUPPLY_MV_IN > `DTTF_VOLT_MAX_MV;
  assign cond[3]  = (SPEED_RPM_IN > `DTTF_SPEED_MAX_RPM) ||
                    (SPEED_RPM_IN < -`DTTF_SPEED_MAX_RPM);
  assign cond[4]  = pin_s_r[1];
  assign cond[5]  = pin_s_r[0];
  assign cond[6]  = ref_sw && pin_s_r[2];
  assign cond[7]  = ref_sw && pin_s_r[3];
  assign cond[8]  = home_exp_r;
  assign cond[9]  = CALIB_FAIL_IN;
  assign cond[10] = pin_s_r[4];
  assign cond[11] = wdog_exp_r;
  assign cond[12] = INDEX_DIST_VALID_IN &&
                    (INDEX_DIST_IN < `DTTF_INDEX_MIN_DECI);

  // level faults record once per rising edge; queued so none is lost
  reg  [NC-1:0] prev_r;
  reg  [NC-1:0] pend_r;
  wire [NC-1:0] rise = cond & ~prev_r;
  wire [NC-1:0] pick = pend_r & (~pend_r + {{(NC-1){1'b0}}, 1'b1});
  reg  [3:0]    pick_slot;
  integer       k;
  always @* begin
    pick_slot = 4'hf;
    for (k = NC - 1; k >= 0; k = k - 1) begin
      if (pick[k]) begin
        pick_slot = k[3:0];
      end
    end
  end

  wire clr_cmd = (SYS_CMD_VALID_IN && SYS_CMD_MODE_IN == `DTTF_SYS_CLR_ERR) ||
                 (OBJ_WRITE_IN && OBJ_MAIN_IN == `DTTF_OBJ_MAIN_ERR &&
                  OBJ_SUB_IN == `DTTF_OBJ_SUB_ERR &&
                  OBJ_WDATA_IN == 32'h0000_0000);
  wire rec = (pend_r != {NC{1'b0}});
  wire [7:0] rec_code = code_of(pick_slot);

  always @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      prev_r            <= {NC{1'b0}};
      pend_r            <= {NC{1'b0}};
      MOTOR_DISABLE_OUT <= 1'b0;
      MOTOR_BRAKE_OUT   <= 1'b0;
      MOTOR_STOP_OUT    <= 1'b0;
      SAVE_STATE_OUT    <= 1'b0;
      ERROR_EVENT_OUT   <= 1'b0;
      LAST_ERROR_OUT    <= `DTTF_ERR_NONE;
      HIST_NEXT_OUT     <= {HIST_AW{1'b0}};
      OBJ_RDATA_OUT     <= 32'h0000_0000;
      OBJ_RVALID_OUT    <= 1'b0;
    end else begin
      prev_r          <= cond;
      pend_r          <= (pend_r & ~pick) | rise;
      SAVE_STATE_OUT  <= rise[1];
      ERROR_EVENT_OUT <= rec;
      if (rise[0] || rise[1] || rise[2] || rise[11]) begin
        MOTOR_DISABLE_OUT <= 1'b1;
      end else if (clr_cmd) begin
        MOTOR_DISABLE_OUT <= 1'b0;
      end
      if (rise[3]) begin
        MOTOR_BRAKE_OUT <= 1'b1;
      end else if (clr_cmd) begin
        MOTOR_BRAKE_OUT <= 1'b0;
      end
      if (rise[4] || rise[5]) begin
        MOTOR_STOP_OUT <= 1'b1;
      end else if (clr_cmd) begin
        MOTOR_STOP_OUT <= 1'b0;
      end
      if (rec) begin
        LAST_ERROR_OUT <= rec_code;
        HIST_NEXT_OUT  <= HIST_NEXT_OUT + {{(HIST_AW-1){1'b0}}, 1'b1};
      end else if (clr_cmd) begin
        LAST_ERROR_OUT <= `DTTF_ERR_NONE;
      end
      OBJ_RVALID_OUT <= OBJ_READ_IN;
      if (OBJ_READ_IN) begin
        OBJ_RDATA_OUT <= (OBJ_MAIN_IN == `DTTF_OBJ_MAIN_ERR &&
                          OBJ_SUB_IN == `DTTF_OBJ_SUB_ERR) ?
                         {24'h00_0000, LAST_ERROR_OUT} : 32'h0000_0000;
      end
    end
  end

  dttf_err_mem #(
    .AW (HIST_AW),
    .DW (8)
  ) u_hist (
    .clk_in      (CORE_CLK_IN),
    .wr_en_in    (rec),
    .wr_addr_in  (HIST_NEXT_OUT),
    .wr_data_in  (rec_code),
    .rd_addr_in  (HIST_IDX_IN),
    .rd_data_out (HIST_DATA_OUT)
  );
endmodule

//--- dttf_host_sink.sv
`timescale 1ns/1ps
module dttf_host_sink (
  input  logic       clk_in,
  input  logic       rst_in,
  input  logic       clr_in,
  input  logic       slow_in,
  input  logic       valid_in,
  input  logic [7:0] data_in,
  input  logic       last_in,
  output logic       ready_out
);
  logic [31:0] words [0:63];
  int          nbytes;
  logic        done;
  logic [1:0]  ph;
  // a slow host takes one byte in three, so held bytes get exercised
  always @(posedge clk_in) begin
    if (rst_in) begin
      ph        <= 2'h0;
      ready_out <= 1'b0;
    end else begin
      ph        <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      ready_out <= !slow_in || ph == 2'h1;
    end
  end
  always @(posedge clk_in) begin
    if (rst_in || clr_in) begin
      nbytes <= 0;
      done   <= 1'b0;
    end else if (valid_in && ready_out) begin
      words[nbytes / 4][8 * (nbytes % 4) +: 8] <= data_in;
      nbytes <= nbytes + 1;
      if (last_in) begin
        done <= 1'b1;
      end
    end
  end
endmodule

//--- dttf_properties.sv
`timescale 1ns/1ps
module dttf_props (
  input logic               CORE_CLK_IN,
  input logic               SYS_RST_IN,
  input logic               TICKET_REQ_IN,
  input logic        [1:0]  TICKET_FMT_IN,
  input logic               CAN_MASTER_IN,
  input logic               TX_READY_IN,
  input logic signed [31:0] BOARD_TEMP_IN,
  input logic signed [31:0] SUPPLY_MV_IN,
  input logic signed [31:0] SPEED_RPM_IN,
  input logic               SYS_CMD_VALID_IN,
  input logic        [7:0]  SYS_CMD_MODE_IN,
  input logic               OBJ_READ_IN,
  input logic        [7:0]  OBJ_MAIN_IN,
  input logic        [7:0]  OBJ_SUB_IN,
  input logic               BUSY_OUT,
  input logic               TICKET_REJECT_OUT,
  input logic        [7:0]  TX_DATA_OUT,
  input logic               TX_VALID_OUT,
  input logic               TX_LAST_OUT,
  input logic               MOTOR_DISABLE_OUT,
  input logic               MOTOR_BRAKE_OUT,
  input logic               SAVE_STATE_OUT,
  input logic               ERROR_EVENT_OUT,
  input logic        [7:0]  LAST_ERROR_OUT,
  input logic        [31:0] OBJ_RDATA_OUT,
  input logic               OBJ_RVALID_OUT
);
  logic take;
  logic hot;
  logic low;
  logic fast;
  assign take = TICKET_REQ_IN && !BUSY_OUT;
  assign hot  = BOARD_TEMP_IN > 32'sh352;
  assign low  = SUPPLY_MV_IN < 32'sh2710;
  assign fast = SPEED_RPM_IN > 32'sh7d0 || SPEED_RPM_IN < -32'sh7d0;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_ticket_start: assert property (
    take && TICKET_FMT_IN == 2'h0 |=> BUSY_OUT ##2 TX_VALID_OUT)
    else $error("ticket start late");
  a_last_release: assert property (
    TX_VALID_OUT && TX_READY_IN && TX_LAST_OUT |=> !BUSY_OUT)
    else $error("busy held after last byte");
  a_slave_refused: assert property (
    take && TICKET_FMT_IN != 2'h0 && !CAN_MASTER_IN
    |=> TICKET_REJECT_OUT && !BUSY_OUT)
    else $error("multi-axis ticket not refused");
  a_byte_hold: assert property (
    TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
    else $error("byte dropped before taken");
  a_over_temp: assert property (
    $rose(hot) |=> MOTOR_DISABLE_OUT ##1
    ERROR_EVENT_OUT && LAST_ERROR_OUT == 8'h10)
    else $error("over temperature not handled");
  a_under_volt: assert property (
    $rose(low) |=> SAVE_STATE_OUT && MOTOR_DISABLE_OUT)
    else $error("under voltage not handled");
  a_over_speed: assert property (
    $rose(fast) |=> MOTOR_BRAKE_OUT)
    else $error("over speed not braked");
  a_err_readback: assert property (
    OBJ_READ_IN && OBJ_MAIN_IN == 8'h03 && OBJ_SUB_IN == 8'h04
    && !ERROR_EVENT_OUT
    |=> OBJ_RVALID_OUT && OBJ_RDATA_OUT == {24'h0, $past(LAST_ERROR_OUT)})
    else $error("last error read back wrong");
  a_clear_last: assert property (
    SYS_CMD_VALID_IN && SYS_CMD_MODE_IN == 8'h05
    |-> ##[1:2] LAST_ERROR_OUT == 8'h00 || ERROR_EVENT_OUT)
    else $error("last error not cleared");

  cover property (TX_VALID_OUT && TX_READY_IN && TX_LAST_OUT);
  cover property (TICKET_REJECT_OUT);
  cover property ($fell(MOTOR_DISABLE_OUT));
endmodule

bind dttf_framer dttf_props i_props (
  .CORE_CLK_IN, .SYS_RST_IN, .TICKET_REQ_IN, .TICKET_FMT_IN,
  .CAN_MASTER_IN, .TX_READY_IN, .BOARD_TEMP_IN, .SUPPLY_MV_IN,
  .SPEED_RPM_IN, .SYS_CMD_VALID_IN, .SYS_CMD_MODE_IN, .OBJ_READ_IN,
  .OBJ_MAIN_IN, .OBJ_SUB_IN, .BUSY_OUT, .TICKET_REJECT_OUT, .TX_DATA_OUT,
  .TX_VALID_OUT, .TX_LAST_OUT, .MOTOR_DISABLE_OUT, .MOTOR_BRAKE_OUT,
  .SAVE_STATE_OUT, .ERROR_EVENT_OUT, .LAST_ERROR_OUT, .OBJ_RDATA_OUT,
  .OBJ_RVALID_OUT
);

//--- dttf_testbench.sv
`timescale 1ns/1ps
module testbench;
  logic CORE_CLK_IN = 0, SYS_RST_IN = 1, TICKET_REQ_IN = 0, slow = 0;
  logic CAN_MASTER_IN = 0, POS_SOFT_LIM_IN = 0, NEG_SOFT_LIM_IN = 0;
  logic POS_SWITCH_IN = 0, NEG_SWITCH_IN = 0, REF_SWITCH_CFG_IN = 1;
  logic AXIS_REFERENCED_IN = 1, HOME_SEARCH_IN = 0, CALIB_FAIL_IN = 0;
  logic STAGE_FAULT_IN = 0, WDOG_EN_IN = 0, WDOG_KICK_IN = 0, clr = 0;
  logic INDEX_DIST_VALID_IN = 0, SYS_CMD_VALID_IN = 0, OBJ_READ_IN = 0;
  logic OBJ_WRITE_IN = 0;
  logic        [1:0]  TICKET_FMT_IN = 0;
  logic        [7:0]  SYS_CMD_MODE_IN = 0, OBJ_MAIN_IN = 0, OBJ_SUB_IN = 0;
  logic        [2:0]  HIST_IDX_IN = 0;
  logic        [15:0] INDEX_DIST_IN = 16'h64;
  logic        [31:0] OBJ_WDATA_IN = 0, WORD_DATA_IN;
  logic signed [31:0] BOARD_TEMP_IN = 32'shfa, SUPPLY_MV_IN = 32'sh5dc0;
  logic signed [31:0] SPEED_RPM_IN = 32'sh64;
  wire        BUSY_OUT, TICKET_REJECT_OUT, TX_VALID_OUT, TX_LAST_OUT;
  wire        MOTOR_DISABLE_OUT, MOTOR_BRAKE_OUT, MOTOR_STOP_OUT;
  wire        SAVE_STATE_OUT, ERROR_EVENT_OUT, OBJ_RVALID_OUT, TX_READY_IN;
  wire [1:0]  WORD_FMT_OUT;
  wire [5:0]  WORD_IDX_OUT;
  wire [7:0]  TX_DATA_OUT, LAST_ERROR_OUT, HIST_DATA_OUT;
  wire [2:0]  HIST_NEXT_OUT;
  wire [31:0] OBJ_RDATA_OUT;
  int         miscompares = 0, checks_done = 0, cyc = 0;
  logic [7:0] codes [13] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
    8'h16, 8'h17, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h32};

  // the low three bytes of a word always differ, so order slips show up
  function logic [31:0] src(input logic [1:0] f, input logic [5:0] i);
    return {f, i, 8'h3c, 2'h0, i, 8'h96};
  endfunction
  function logic [2:0] acts(input logic [7:0] c);
    return {c inside {8'h10, 8'h11, 8'h12, 8'h1c}, c == 8'h13,
            c inside {8'h14, 8'h15}};
  endfunction
  assign WORD_DATA_IN = src(WORD_FMT_OUT, WORD_IDX_OUT);

  dttf_framer #(.HOME_TMO_US(8), .WDOG_TMO_US(20)) i_dut (
    .CORE_CLK_IN, .SYS_RST_IN, .TICKET_REQ_IN, .TICKET_FMT_IN,
    .CAN_MASTER_IN, .WORD_DATA_IN, .TX_READY_IN, .BOARD_TEMP_IN,
    .SUPPLY_MV_IN, .SPEED_RPM_IN, .POS_SOFT_LIM_IN, .NEG_SOFT_LIM_IN,
    .POS_SWITCH_IN, .NEG_SWITCH_IN, .REF_SWITCH_CFG_IN,
    .AXIS_REFERENCED_IN, .HOME_SEARCH_IN, .CALIB_FAIL_IN, .STAGE_FAULT_IN,
    .WDOG_EN_IN, .WDOG_KICK_IN, .INDEX_DIST_IN, .INDEX_DIST_VALID_IN,
    .SYS_CMD_VALID_IN, .SYS_CMD_MODE_IN, .OBJ_READ_IN, .OBJ_WRITE_IN,
    .OBJ_MAIN_IN, .OBJ_SUB_IN, .OBJ_WDATA_IN, .HIST_IDX_IN, .BUSY_OUT,
    .TICKET_REJECT_OUT, .WORD_FMT_OUT, .WORD_IDX_OUT, .TX_DATA_OUT,
    .TX_VALID_OUT, .TX_LAST_OUT, .MOTOR_DISABLE_OUT, .MOTOR_BRAKE_OUT,
    .MOTOR_STOP_OUT, .SAVE_STATE_OUT, .ERROR_EVENT_OUT, .LAST_ERROR_OUT,
    .OBJ_RDATA_OUT, .OBJ_RVALID_OUT, .HIST_DATA_OUT, .HIST_NEXT_OUT);
  dttf_host_sink i_host (.clk_in(CORE_CLK_IN), .rst_in(SYS_RST_IN),
    .clr_in(clr), .slow_in(slow), .valid_in(TX_VALID_OUT),
    .data_in(TX_DATA_OUT), .last_in(TX_LAST_OUT), .ready_out(TX_READY_IN));

  initial forever #2 CORE_CLK_IN = ~CORE_CLK_IN;
  always @(posedge CORE_CLK_IN) cyc <= SYS_RST_IN ? 0 : cyc + 1;

  task close_out;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task guard(input logic ok);
    chk(ok, 1'b1);
    if (ok !== 1'b1) close_out;
  endtask

  task ticket(input logic [1:0] f, input int nw);
    int n;
    logic [31:0] t0;
    @(posedge CORE_CLK_IN);
    clr <= 1'b1;
    @(posedge CORE_CLK_IN);
    clr <= 1'b0;
    TICKET_FMT_IN <= f;
    TICKET_REQ_IN <= 1'b1;
    t0 = cyc / 250;
    @(posedge CORE_CLK_IN);
    TICKET_REQ_IN <= 1'b0;
    for (n = 0; n < 40000 && i_host.done !== 1'b1; n++) begin
      @(posedge CORE_CLK_IN);
      #1;
    end
    guard(i_host.done);
    chk(i_host.nbytes, 4 * nw);
    chk(i_host.words[0] - t0 + 32'h1 < 32'h3, 1'b1);
    for (n = 1; n < nw; n++)
      chk(i_host.words[n], (f == 2'h0 && n == 8) ? '0 : src(f, n));
  endtask

  task refuse(input logic [1:0] f);
    @(posedge CORE_CLK_IN);
    TICKET_FMT_IN <= f;
    TICKET_REQ_IN <= 1'b1;
    @(posedge CORE_CLK_IN);
    TICKET_REQ_IN <= 1'b0;
    #1;
    chk({TICKET_REJECT_OUT, BUSY_OUT}, 2'h2);
  endtask

  task fault(input int k);
    int n;
    logic [7:0] c;
    logic [2:0] slot;
    c = codes[k];
    @(posedge CORE_CLK_IN);
    slot = HIST_NEXT_OUT;
    case (k)
      0: BOARD_TEMP_IN <= 32'sh353;
      1: SUPPLY_MV_IN <= 32'sh270f;
      2: SUPPLY_MV_IN <= 32'sh7531;
      3: SPEED_RPM_IN <= -32'sh7d1;
      4: POS_SOFT_LIM_IN <= 1'b1;
      5: NEG_SOFT_LIM_IN <= 1'b1;
      6: NEG_SWITCH_IN <= 1'b1;
      7: POS_SWITCH_IN <= 1'b1;
      8: HOME_SEARCH_IN <= 1'b1;
      9: CALIB_FAIL_IN <= 1'b1;
      10: STAGE_FAULT_IN <= 1'b1;
      11: WDOG_EN_IN <= 1'b1;
      default: begin
        INDEX_DIST_IN <= 16'h31;
        INDEX_DIST_VALID_IN <= 1'b1;
      end
    endcase
    @(posedge CORE_CLK_IN);
    INDEX_DIST_VALID_IN <= 1'b0;
    if (k == 11) begin
      // a kick before the timeout must restart the count
      repeat (4000) @(posedge CORE_CLK_IN);
      WDOG_KICK_IN <= 1'b1;
      @(posedge CORE_CLK_IN);
      WDOG_KICK_IN <= 1'b0;
      repeat (4000) @(posedge CORE_CLK_IN);
      #1;
      chk(LAST_ERROR_OUT, 8'h00);
    end
    for (n = 0; n < 6000 && ERROR_EVENT_OUT !== 1'b1; n++) begin
      @(posedge CORE_CLK_IN);
      #1;
    end
    guard(ERROR_EVENT_OUT);
    chk(LAST_ERROR_OUT, c);
    chk({MOTOR_DISABLE_OUT, MOTOR_BRAKE_OUT, MOTOR_STOP_OUT}, acts(c));
    chk(HIST_NEXT_OUT, 3'(slot + 3'h1));
    @(posedge CORE_CLK_IN);
    {POS_SOFT_LIM_IN, NEG_SOFT_LIM_IN, POS_SWITCH_IN, NEG_SWITCH_IN} <= '0;
    {HOME_SEARCH_IN, CALIB_FAIL_IN, STAGE_FAULT_IN, WDOG_EN_IN} <= '0;
    BOARD_TEMP_IN <= 32'shfa;
    SUPPLY_MV_IN <= 32'sh5dc0;
    SPEED_RPM_IN <= 32'sh64;
    INDEX_DIST_IN <= 16'h64;
    {OBJ_MAIN_IN, OBJ_SUB_IN} <= 16'h0304;
    OBJ_READ_IN <= 1'b1;
    HIST_IDX_IN <= slot;
    @(posedge CORE_CLK_IN);
    OBJ_READ_IN <= 1'b0;
    OBJ_WRITE_IN <= k[0];
    OBJ_WDATA_IN <= '0;
    SYS_CMD_VALID_IN <= !k[0];
    SYS_CMD_MODE_IN <= 8'h05;
    #1;
    chk(OBJ_RVALID_OUT, 1'b1);
    chk(OBJ_RDATA_OUT, {24'h0, c});
    chk(HIST_DATA_OUT, c);
    @(posedge CORE_CLK_IN);
    {OBJ_WRITE_IN, SYS_CMD_VALID_IN} <= 2'h0;
    repeat (2) @(posedge CORE_CLK_IN);
    #1;
    chk({LAST_ERROR_OUT, MOTOR_DISABLE_OUT, MOTOR_BRAKE_OUT, MOTOR_STOP_OUT},
        '0);
  endtask

  // a switch on an axis not set up for referencing must record nothing
  task no_ref;
    @(posedge CORE_CLK_IN);
    {REF_SWITCH_CFG_IN, NEG_SWITCH_IN} <= 2'h1;
    repeat (6) @(posedge CORE_CLK_IN);
    NEG_SWITCH_IN <= 1'b0;
    #1;
    chk(LAST_ERROR_OUT, 8'h00);
    repeat (4) @(posedge CORE_CLK_IN);
    REF_SWITCH_CFG_IN <= 1'b1;
  endtask

  initial begin
    repeat (20) @(posedge CORE_CLK_IN);
    SYS_RST_IN <= 1'b0;
    ticket(2'h0, 31);
    @(posedge CORE_CLK_IN);
    CAN_MASTER_IN <= 1'b1;
    slow <= 1'b1;
    ticket(2'h1, 29);
    ticket(2'h2, 49);
    refuse(2'h3);
    @(posedge CORE_CLK_IN);
    CAN_MASTER_IN <= 1'b0;
    for (int f = 1; f < 4; f++) refuse(f);
    no_ref;
    for (int k = 0; k < 13; k++) fault(k);
    close_out;
  end
endmodule
